// ===== rtl/ghp_port_regs.vh
// Constants of the host port select and status block
`ifndef GHP_PORT_REGS_VH
`define GHP_PORT_REGS_VH
// Core clock period
`define GHP_CLK_NS 4
// Pin synchroniser bit positions
`define GHP_SY_P18 0
`define GHP_SY_P19 1
`define GHP_SY_P21 2
`define GHP_SY_SEL 3
`define GHP_SY_TP 4
`define GHP_SY_W 5
// Strap settle count after reset release
`define GHP_STRAP_SETTLE 2'h3
// SPI byte width and idle filler
`define GHP_BITS_LAST 3'h7
`define GHP_SPI_IDLE 8'hff
// Sustained SPI payload limit and least byte spacing
`define GHP_SPI_KBPS 125
`define GHP_SPI_BYTE_NS (1000000 / `GHP_SPI_KBPS)
`define GHP_SPI_BYTE_CYC (`GHP_SPI_BYTE_NS / `GHP_CLK_NS)
// Wake delay and correction blink half period
`define GHP_WAKE_US 1000
`define GHP_WAKE_CYC ((`GHP_WAKE_US * 1000) / `GHP_CLK_NS)
`define GHP_BLINK_MS 250
`define GHP_BLINK_CYC ((`GHP_BLINK_MS * 1000000) / `GHP_CLK_NS)
`endif

// ===== rtl/ghp_sync.v
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module ghp_sync #(
   parameter W = 1
) (
   input wire core_clk_i,
   input wire reset_n_i,
   input wire [W-1:0] async_i,
   input wire [W-1:0] reset_val_i,
   output reg [W-1:0] sync_o
);
   reg [W-1:0] meta_q;
   // Reset loads all ones; the reset_val_i input is not used
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         meta_q <= {W{1'b1}};
         sync_o <= {W{1'b1}};
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule // ghp_sync
`default_nettype wire

// ===== rtl/ghp_buf2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ghp_buf2 #(
   parameter W = 8
) (
   input wire core_clk_i,
   input wire reset_n_i,
   input wire [W-1:0] in_data_i,
   input wire in_valid_i,
   output wire in_ready_o,
   output reg [W-1:0] out_data_o,
   output reg out_valid_o,
   input wire out_ready_i
);
   reg [W-1:0] slot1_q;
   reg full1_q;
   wire pop;
   wire push;
   assign in_ready_o = ~full1_q;
   assign pop = out_valid_o & out_ready_i;
   assign push = in_valid_i & ~full1_q;
   // Head slot drives the output straight from flops
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         out_data_o <= {W{1'b0}};
         out_valid_o <= 1'b0;
         slot1_q <= {W{1'b0}};
         full1_q <= 1'b0;
      end
      else
      begin
         if (!out_valid_o || pop)
         begin
            if (full1_q)
            begin
               out_data_o <= slot1_q;
               out_valid_o <= 1'b1;
               full1_q <= push;
               slot1_q <= in_data_i;
            end
            else
            begin
               out_data_o <= in_data_i;
               out_valid_o <= push;
            end
         end
         else if (push)
         begin
            slot1_q <= in_data_i;
            full1_q <= 1'b1;
         end
      end
   end
endmodule // ghp_buf2
`default_nettype wire

// ===== rtl/ghp_port_select.v
// Host port select, SPI target, time pulse and status pins
// Function
// - Time pulse train aligned to time grid
// - Time pulse off until explicitly enabled
// - Low time pulse pin at start: recovery
// - SPI is target only, clock limit
// - SPI throughput need not exceed 125 kB/s
// - SPI only when select tied low
// - Select routes shared pins SPI or UART/I2C
// - Two-wire port is target only, 400 kHz
// - Same byte stream on every host port
// - USB full-speed pull-up on positive line
// - Backup halt, wake on receive edge, delay
// - Clock runs, rest off, RAM kept
// - Correction pin: 0 fixed, toggling, 1 none
// - Select evaluated at start, then persists
// - Zone pin low inside any zone
`timescale 1ns/1ps
`default_nettype none
`include "ghp_port_regs.vh"
module ghp_port_select #(
   parameter ZONES = 4,
   parameter TPW = 32,
   parameter WAKE_CYCLES = `GHP_WAKE_CYC,
   parameter BLINK_CYCLES = `GHP_BLINK_CYC
) (
   input wire core_clk_i,
   input wire reset_n_i,
   input wire if_select_i,
   input wire pin18_i,
   output reg pin18_o,
   output reg pin18_oe_o,
   input wire pin19_i,
   output reg pin19_o,
   output reg pin19_oe_o,
   output reg pin20_o,
   output reg pin20_oe_o,
   input wire pin21_i,
   output reg spi_mode_o,
   output reg recovery_boot_o,
   output reg uart_rxd_o,
   input wire uart_txd_i,
   output reg two_wire_sda_o,
   output reg two_wire_scl_o,
   input wire two_wire_sda_low_i,
   output wire [7:0] rx_data_o,
   output wire rx_valid_o,
   input wire rx_ready_i,
   output reg rx_overrun_o,
   input wire [7:0] tx_data_i,
   input wire tx_valid_i,
   output reg tx_ready_o,
   input wire tp_enable_i,
   input wire [TPW-1:0] tp_period_i,
   input wire [TPW-1:0] tp_width_i,
   input wire grid_tick_i,
   input wire timepulse_i,
   output reg timepulse_o,
   output reg timepulse_oe_o,
   input wire fix_i,
   input wire corr_arriving_i,
   output reg correction_fix_status_o,
   input wire [ZONES-1:0] zone_inside_i,
   output reg zone_status_o,
   output reg usb_dp_pullup_o,
   input wire backup_req_i,
   output reg awake_o,
   output reg host_ready_o,
   input wire main_power_good_i,
   output reg rtc_run_o,
   output reg logic_power_en_o,
   output reg backup_ram_retain_o
);
   ////////////////////////////////////////////////////////////////////
   wire [`GHP_SY_W-1:0] sy;
   wire [`GHP_SY_W-1:0] sy_rst;
   assign sy_rst = {`GHP_SY_W{1'b1}};
   ghp_sync #(.W(`GHP_SY_W)) u_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .async_i({timepulse_i, if_select_i, pin21_i, pin19_i, pin18_i}),
      .reset_val_i(sy_rst),
      .sync_o(sy)
   );
   wire p18_s = sy[`GHP_SY_P18];
   wire p19_s = sy[`GHP_SY_P19];
   wire p21_s = sy[`GHP_SY_P21];

   ////////////////////////////////////////////////////////////////////
   // Straps
   reg [1:0] settle_q;
   reg taken_q;
   reg spi_q;
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         settle_q <= 2'h0;
         taken_q <= 1'b0;
         spi_q <= 1'b0;
         spi_mode_o <= 1'b0;
         recovery_boot_o <= 1'b0;
      end
      else if (!taken_q)
      begin
         // Wait for the synchroniser to hold pin levels
         settle_q <= settle_q + 2'h1;
         if (settle_q == `GHP_STRAP_SETTLE)
         begin
            taken_q <= 1'b1;
            spi_q <= ~sy[`GHP_SY_SEL];
            spi_mode_o <= ~sy[`GHP_SY_SEL];
            recovery_boot_o <= ~sy[`GHP_SY_TP];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // SPI target, mode 0
   reg sck_prev_q;
   reg [2:0] bit_q;
   reg [7:0] rx_sh_q;
   reg [7:0] tx_sh_q;
   reg [7:0] tx_hold_q;
   reg hold_full_q;
   reg byte_done_q;
   reg [7:0] byte_q;
   wire buf_ready;
   wire spi_act = taken_q & spi_q & ~p18_s;
   wire sck_rise = spi_act & p19_s & ~sck_prev_q;
   wire sck_fall = spi_act & ~p19_s & sck_prev_q;
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sck_prev_q <= 1'b0;
         bit_q <= 3'h0;
         rx_sh_q <= 8'h00;
         tx_sh_q <= `GHP_SPI_IDLE;
         tx_hold_q <= 8'h00;
         hold_full_q <= 1'b0;
         byte_done_q <= 1'b0;
         byte_q <= 8'h00;
         tx_ready_o <= 1'b0;
         rx_overrun_o <= 1'b0;
      end
      else
      begin
         sck_prev_q <= p19_s;
         byte_done_q <= 1'b0;
         tx_ready_o <= 1'b0;
         if (tx_valid_i && !hold_full_q && !tx_ready_o)
         begin
            tx_hold_q <= tx_data_i;
            hold_full_q <= 1'b1;
            tx_ready_o <= 1'b1;
         end
         if (!spi_act)
         begin
            // Deselect abandons a partial byte; a loaded byte waits for the next frame
            bit_q <= 3'h0;
            if (hold_full_q)
            begin
               tx_sh_q <= tx_hold_q;
               hold_full_q <= 1'b0;
            end
            else if (bit_q != 3'h0)
            begin
               tx_sh_q <= `GHP_SPI_IDLE;
            end
         end
         else if (sck_rise)
         begin
            rx_sh_q <= {rx_sh_q[6:0], p21_s};
            bit_q <= bit_q + 3'h1;
            if (bit_q == `GHP_BITS_LAST)
            begin
               byte_q <= {rx_sh_q[6:0], p21_s};
               byte_done_q <= 1'b1;
            end
         end
         else if (sck_fall)
         begin
            if (bit_q == 3'h0 && hold_full_q)
            begin
               tx_sh_q <= tx_hold_q;
               hold_full_q <= 1'b0;
            end
            else if (bit_q == 3'h0)
            begin
               tx_sh_q <= `GHP_SPI_IDLE;
            end
            else
            begin
               tx_sh_q <= {tx_sh_q[6:0], 1'b1};
            end
         end
         // Host cannot be stalled: a word into a full buffer is flagged
         if (byte_done_q && !buf_ready)
         begin
            rx_overrun_o <= 1'b1;
         end
      end
   end

   // Two entries cover the least byte spacing at the rated throughput
   ghp_buf2 #(.W(8)) u_rx_buf (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .in_data_i(byte_q),
      .in_valid_i(byte_done_q),
      .in_ready_o(buf_ready),
      .out_data_o(rx_data_o),
      .out_valid_o(rx_valid_o),
      .out_ready_i(rx_ready_i)
   );

   ////////////////////////////////////////////////////////////////////
   // Shared pin routing
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pin18_o <= 1'b0;
         pin18_oe_o <= 1'b0;
         pin19_o <= 1'b0;
         pin19_oe_o <= 1'b0;
         pin20_o <= 1'b1;
         pin20_oe_o <= 1'b0;
         uart_rxd_o <= 1'b1;
         two_wire_sda_o <= 1'b1;
         two_wire_scl_o <= 1'b1;
         usb_dp_pullup_o <= 1'b0;
      end
      else
      begin
         usb_dp_pullup_o <= 1'b1;
         pin18_o <= 1'b0;
         pin19_o <= 1'b0;
         pin19_oe_o <= 1'b0;
         if (!taken_q)
         begin
            pin18_oe_o <= 1'b0;
            pin20_oe_o <= 1'b0;
         end
         else if (spi_q)
         begin
            pin18_oe_o <= 1'b0;
            pin20_o <= tx_sh_q[7];
            pin20_oe_o <= ~p18_s;
            uart_rxd_o <= 1'b1;
            two_wire_sda_o <= 1'b1;
            two_wire_scl_o <= 1'b1;
         end
         else
         begin
            pin18_oe_o <= two_wire_sda_low_i;
            pin20_o <= uart_txd_i;
            pin20_oe_o <= 1'b1;
            uart_rxd_o <= p21_s;
            two_wire_sda_o <= p18_s;
            two_wire_scl_o <= p19_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Time pulse
   reg [TPW-1:0] tp_cnt_q;
   wire [TPW-1:0] tp_one = {{(TPW-1){1'b0}}, 1'b1};
   // Pulse follows the count being entered, so each period starts high
   wire tp_wrap = !tp_enable_i || grid_tick_i || (tp_cnt_q >= tp_period_i - tp_one);
   wire [TPW-1:0] tp_next = tp_wrap ? {TPW{1'b0}} : tp_cnt_q + tp_one;
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         tp_cnt_q <= {TPW{1'b0}};
         timepulse_o <= 1'b0;
         timepulse_oe_o <= 1'b0;
      end
      else
      begin
         // Pin stays undriven until straps are caught
         timepulse_oe_o <= taken_q;
         tp_cnt_q <= tp_next;
         if (!tp_enable_i || !taken_q)
         begin
            timepulse_o <= 1'b0;
         end
         else
         begin
            timepulse_o <= tp_next < tp_width_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status pins
   reg [31:0] blink_q;
   reg [31:0] wake_q;
   reg rxd_prev_q;
   reg halted_q;
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         blink_q <= 32'h0000_0000;
         correction_fix_status_o <= 1'b1;
         zone_status_o <= 1'b1;
      end
      else
      begin
         zone_status_o <= ~(|zone_inside_i);
         if (fix_i)
         begin
            correction_fix_status_o <= 1'b0;
            blink_q <= 32'h0000_0000;
         end
         else if (!corr_arriving_i)
         begin
            correction_fix_status_o <= 1'b1;
            blink_q <= 32'h0000_0000;
         end
         else if (blink_q >= BLINK_CYCLES - 1)
         begin
            correction_fix_status_o <= ~correction_fix_status_o;
            blink_q <= 32'h0000_0000;
         end
         else
         begin
            blink_q <= blink_q + 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Software backup and power domains
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rxd_prev_q <= 1'b1;
         halted_q <= 1'b0;
         wake_q <= 32'h0000_0000;
         awake_o <= 1'b1;
         host_ready_o <= 1'b0;
         rtc_run_o <= 1'b1;
         logic_power_en_o <= 1'b1;
         backup_ram_retain_o <= 1'b0;
      end
      else
      begin
         rxd_prev_q <= p21_s;
         rtc_run_o <= 1'b1;
         logic_power_en_o <= main_power_good_i & ~halted_q;
         backup_ram_retain_o <= ~main_power_good_i | halted_q;
         if (!halted_q && backup_req_i)
         begin
            halted_q <= 1'b1;
            awake_o <= 1'b0;
            host_ready_o <= 1'b0;
            wake_q <= 32'h0000_0000;
         end
         else if (halted_q)
         begin
            if (p21_s != rxd_prev_q)
            begin
               halted_q <= 1'b0;
               awake_o <= 1'b1;
            end
         end
         else if (!host_ready_o)
         begin
            // Host must not talk until the restart delay has run out
            if (wake_q >= WAKE_CYCLES - 1)
            begin
               host_ready_o <= 1'b1;
            end
            else
            begin
               wake_q <= wake_q + 32'h0000_0001;
            end
         end
      end
   end
endmodule // ghp_port_select
`default_nettype wire

// ===== bench/ghp_port_select_monitor.sv
// Checker of strap, routing and status pin behaviour
`timescale 1ns/1ps
`default_nettype none
module ghp_port_select_monitor #(
   parameter ZONES = 4
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic if_select_i,
   input wire logic timepulse_i,
   input wire logic spi_mode_o,
   input wire logic recovery_boot_o,
   input wire logic uart_txd_i,
   input wire logic pin20_o,
   input wire logic pin20_oe_o,
   input wire logic fix_i,
   input wire logic corr_arriving_i,
   input wire logic correction_fix_status_o,
   input wire logic [ZONES-1:0] zone_inside_i,
   input wire logic zone_status_o,
   input wire logic tp_enable_i,
   input wire logic timepulse_o,
   input wire logic backup_req_i,
   input wire logic awake_o,
   input wire logic host_ready_o,
   input wire logic usb_dp_pullup_o
);
////////////////////////////////////////
// Edges since reset release, saturating
logic [2:0] age_q;
always_ff @(posedge core_clk_i or negedge reset_n_i)
   if (!reset_n_i)
      age_q <= 3'h0;
   else if (age_q != 3'h7)
      age_q <= age_q + 3'h1;
default clocking @(posedge core_clk_i); endclocking
default disable iff (!reset_n_i);
////////////////////////////////////////
// Wake delay bounded loosely, exact count is a design choice
sequence ready_wait_s;
   !host_ready_o [*8] ##[1:40] host_ready_o;
endsequence
strap_capture_a: assert property (age_q == 3'h6 |-> spi_mode_o == !if_select_i && recovery_boot_o == !timepulse_i)
   else $error("strap capture wrong");
strap_hold_a: assert property (age_q == 3'h7 |-> $stable(spi_mode_o) && $stable(recovery_boot_o))
   else $error("strap changed in run");
uart_route_a: assert property (age_q == 3'h7 && !spi_mode_o |=> pin20_oe_o && pin20_o == $past(uart_txd_i))
   else $error("transmit pin not routed");
fix_low_a: assert property (fix_i |=> !correction_fix_status_o)
   else $error("fixed state not low");
no_corr_a: assert property (!fix_i && !corr_arriving_i |=> correction_fix_status_o)
   else $error("no corrections not high");
zone_state_a: assert property (1'b1 |=> zone_status_o == ($past(zone_inside_i) == '0))
   else $error("zone pin wrong");
tp_off_a: assert property (!tp_enable_i [*2] |-> !timepulse_o)
   else $error("pulse while disabled");
sleep_now_a: assert property (backup_req_i |=> !awake_o && !host_ready_o)
   else $error("backup not entered");
wake_delay_a: assert property ($rose(awake_o) |-> ready_wait_s)
   else $error("wake delay wrong");
pullup_on_a: assert property (age_q == 3'h7 |-> usb_dp_pullup_o)
   else $error("pull-up missing");
endmodule // ghp_port_select_monitor
bind ghp_port_select ghp_port_select_monitor #(.ZONES(ZONES)) u_mon (.core_clk_i, .reset_n_i, .if_select_i,
   .timepulse_i, .spi_mode_o, .recovery_boot_o, .uart_txd_i, .pin20_o, .pin20_oe_o, .fix_i, .corr_arriving_i,
   .correction_fix_status_o, .zone_inside_i, .zone_status_o, .tp_enable_i, .timepulse_o, .backup_req_i,
   .awake_o, .host_ready_o, .usb_dp_pullup_o);
`default_nettype wire

// ===== bench/ghp_spi_host.sv
// Host controller model of the SPI link
`timescale 1ns/1ps
`default_nettype none
module ghp_spi_host (
   input wire logic core_clk_i,
   input wire logic miso_i,
   output var logic cs_n_o,
   output var logic sclk_o,
   output var logic mosi_o
);
////////////////////////////////////////
initial
begin
   cs_n_o = 1'b1;
   sclk_o = 1'b0;
   mosi_o = 1'b1;
end
// Controller role, mode 0, clock still between bytes
task automatic xfer(input logic [7:0] tx, input int gap, output logic [7:0] rx);
   repeat (gap) @(posedge core_clk_i);
   #1 cs_n_o = 1'b0;
   for (int i = 7; i >= 0; i--)
   begin
      mosi_o = tx[i];
      #24 sclk_o = 1'b1;
      rx[i] = miso_i;
      #24 sclk_o = 1'b0;
   end
   // Released line shows no stale bit
   mosi_o = ~mosi_o;
endtask
task automatic stop();
   #24 cs_n_o = 1'b1;
endtask
task automatic toggle();
   #1 mosi_o = ~mosi_o;
endtask
endmodule // ghp_spi_host
`default_nettype wire

// ===== bench/test_ghp_port_select.sv
// Testbench of the host port select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) \
   begin \
      n_tests++; \
      if ((s) !== (e)) \
      begin \
         mismatches++; \
         $display("wrong value %s exp %h got %h", n, e, s); \
      end \
   end
module test_ghp_port_select;
////////////////////////////////////////
logic core_clk_i = 0, reset_n_i = 0, if_select_i = 1, timepulse_i = 1, uart_txd_i = 1;
logic two_wire_sda_low_i = 0, rx_ready_i = 1, tx_valid_i = 0, tp_enable_i = 0, grid_tick_i = 0;
logic fix_i = 0, corr_arriving_i = 0, backup_req_i = 0, main_power_good_i = 1;
logic [7:0] tx_data_i = 8'h00, rx_data_o, got;
logic [31:0] tp_period_i = 32'h0000_000a, tp_width_i = 32'h0000_0003;
logic [3:0] zone_inside_i = 4'h0;
logic pin18_o, pin18_oe_o, pin19_o, pin19_oe_o, pin20_o, pin20_oe_o, spi_mode_o, recovery_boot_o;
logic uart_rxd_o, two_wire_sda_o, two_wire_scl_o, rx_valid_o, rx_overrun_o, tx_ready_o, timepulse_o;
logic timepulse_oe_o, correction_fix_status_o, zone_status_o, usb_dp_pullup_o, awake_o, host_ready_o;
logic rtc_run_o, logic_power_en_o, backup_ram_retain_o, prev;
wire cs_n, sclk, pin21_i;
int mismatches = 0, n_tests = 0, k;
// Open-drain wires idle high; undriven transmit pin shows inverse
wire pin18_i = cs_n & ~pin18_oe_o;
wire pin19_i = sclk & ~pin19_oe_o;
wire miso = pin20_oe_o ? pin20_o : ~pin20_o;
// Rows: fix, arriving, zones, expected status, expected zone pin
logic [7:0] rows [6] = '{8'h81, 8'hc4, 8'h22, 8'h03, 8'h90, 8'h0a};
logic [7:0] exp_rx [2] = '{8'h3c, 8'h11};
initial forever #2 core_clk_i = ~core_clk_i;
ghp_port_select #(.WAKE_CYCLES(20), .BLINK_CYCLES(10)) DUT (.core_clk_i, .reset_n_i, .if_select_i,
   .pin18_i, .pin18_o, .pin18_oe_o, .pin19_i, .pin19_o, .pin19_oe_o, .pin20_o, .pin20_oe_o, .pin21_i,
   .spi_mode_o, .recovery_boot_o, .uart_rxd_o, .uart_txd_i, .two_wire_sda_o, .two_wire_scl_o,
   .two_wire_sda_low_i, .rx_data_o, .rx_valid_o, .rx_ready_i, .rx_overrun_o, .tx_data_i, .tx_valid_i,
   .tx_ready_o, .tp_enable_i, .tp_period_i, .tp_width_i, .grid_tick_i, .timepulse_i, .timepulse_o,
   .timepulse_oe_o, .fix_i, .corr_arriving_i, .correction_fix_status_o, .zone_inside_i, .zone_status_o,
   .usb_dp_pullup_o, .backup_req_i, .awake_o, .host_ready_o, .main_power_good_i, .rtc_run_o,
   .logic_power_en_o, .backup_ram_retain_o);
ghp_spi_host u_host (.core_clk_i, .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(pin21_i));
////////////////////////////////////////
task automatic tick(input int n);
   repeat (n) @(posedge core_clk_i);
endtask
task automatic end_of_test();
   $display("comparisons %0d mismatches %0d", n_tests, mismatches);
   if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
   else
      $display("Simulation failed");
   $finish;
endtask
task automatic wait_hi(ref logic s, input string n);
   int c = 0;
   while (s !== 1'b1 && c < 2000)
   begin
      tick(1);
      c++;
   end
   if (s !== 1'b1)
   begin
      mismatches++;
      $display("wrong value %s exp 1 got %b", n, s);
      end_of_test();
   end
endtask
task automatic do_reset(input logic sel, input logic tp);
   reset_n_i <= 1'b0;
   if_select_i <= sel;
   timepulse_i <= tp;
   tick(5);
   reset_n_i <= 1'b1;
   tick(8);
endtask
////////////////////////////////////////
initial
begin
   tick(1);
   do_reset(1'b1, 1'b1);
   foreach (rows[i])
   begin
      {fix_i, corr_arriving_i, zone_inside_i} <= rows[i][7:2];
      tick(3);
      `CHK("status", rows[i][1], correction_fix_status_o)
      `CHK("zone", rows[i][0], zone_status_o)
   end
   // Default strap: UART and two-wire, no SPI
   `CHK("spi mode", 1'b0, spi_mode_o)
   `CHK("recovery", 1'b0, recovery_boot_o)
   `CHK("scl oe", 1'b0, pin19_oe_o)
   `CHK("pullup", 1'b1, usb_dp_pullup_o)
   `CHK("pulse off", 1'b0, timepulse_o)
   uart_txd_i <= 1'b0;
   two_wire_sda_low_i <= 1'b1;
   tick(5);
   `CHK("txd", 1'b0, pin20_o)
   `CHK("rxd", pin21_i, uart_rxd_o)
   `CHK("sda oe", 1'b1, pin18_oe_o)
   `CHK("sda in", 1'b0, two_wire_sda_o)
   `CHK("scl in", 1'b0, two_wire_scl_o)
   two_wire_sda_low_i <= 1'b0;
   // Correction data arriving: pin must blink
   {fix_i, corr_arriving_i} <= 2'h1;
   tick(2);
   prev = correction_fix_status_o;
   k = 0;
   repeat (30)
   begin
      tick(1);
      if (correction_fix_status_o !== prev)
         k++;
      prev = correction_fix_status_o;
   end
   `CHK("blink", 1'b1, k >= 2)
   // Pulse train: 3 high of every 10, four periods
   tp_enable_i <= 1'b1;
   grid_tick_i <= 1'b1;
   tick(1);
   grid_tick_i <= 1'b0;
   tick(3);
   k = 0;
   repeat (40)
   begin
      tick(1);
      k += timepulse_o;
   end
   `CHK("pulse count", 12, k)
   `CHK("pulse oe", 1'b1, timepulse_oe_o)
   // Software backup, wake on receive edge
   backup_req_i <= 1'b1;
   tick(1);
   backup_req_i <= 1'b0;
   tick(2);
   `CHK("asleep", 1'b0, awake_o)
   u_host.toggle();
   wait_hi(awake_o, "awake");
   wait_hi(host_ready_o, "host ready");
   main_power_good_i <= 1'b0;
   tick(3);
   `CHK("power", 3'h5, {rtc_run_o, logic_power_en_o, backup_ram_retain_o})
   main_power_good_i <= 1'b1;
   // SPI strap with recovery strap low
   do_reset(1'b0, 1'b0);
   `CHK("spi mode", 1'b1, spi_mode_o)
   `CHK("recovery", 1'b1, recovery_boot_o)
   if_select_i <= 1'b1;
   tick(10);
   `CHK("persist", 1'b1, spi_mode_o)
   `CHK("rxd idle", 1'b1, uart_rxd_o)
   `CHK("miso oe", 1'b0, pin20_oe_o)
   tx_data_i <= 8'ha5;
   tx_valid_i <= 1'b1;
   wait_hi(tx_ready_o, "tx ready");
   tx_valid_i <= 1'b0;
   // Receiver stalls: third byte overruns
   rx_ready_i <= 1'b0;
   u_host.xfer(8'h3c, 2, got);
   `CHK("miso", 8'ha5, got)
   u_host.xfer(8'h11, 0, got);
   `CHK("miso idle", 8'hff, got)
   u_host.xfer(8'h22, 20, got);
   u_host.stop();
   tick(10);
   `CHK("overrun", 1'b1, rx_overrun_o)
   foreach (exp_rx[i])
   begin
      `CHK("rx data", exp_rx[i], rx_data_o)
      rx_ready_i <= 1'b1;
      tick(1);
      rx_ready_i <= 1'b0;
      tick(1);
   end
   `CHK("rx empty", 1'b0, rx_valid_o)
   end_of_test();
end
endmodule // test_ghp_port_select
`default_nettype wire
